// file: hw/dph_map.svh
// Constants shared by the DDR3 PHY end and the DFI controller end
`ifndef DPH_MAP_SVH
`define DPH_MAP_SVH
`define DPH_DW 32
`define DPH_MW 4
`define DPH_AW 14
`define DPH_BW 3
`define DPH_CSW 1
`define DPH_CKEW 1
`define DPH_CLKOW 1
`define DPH_DQSW 2
`define DPH_LINK_NS 80
`define DPH_GAP_US 500
`define DPH_GAP_CYC ((`DPH_GAP_US * 1000 + `DPH_LINK_NS - 1) / `DPH_LINK_NS)
`define DPH_MRS_CYC 16
`define DPH_WLV_CYC 32
`define DPH_CORE_LAT 9
`define DPH_RL_MCK 6
`define DPH_RD_LAT (`DPH_CORE_LAT + (`DPH_RL_MCK + 1) / 2)
`define DPH_WL_MCK 5
`define DPH_WR_LAT ((`DPH_WL_MCK + 1) / 2)
`define DPH_BURST_WORDS 2
`define DPH_CNT_W 16
`endif

// file: hw/dph_pkg.sv
// Types and command decoding for the DDR3 PHY port
package dph_pkg;
  typedef enum logic [2:0] {
    DPH_CMD_NOP, DPH_CMD_ACT, DPH_CMD_RD, DPH_CMD_WR,
    DPH_CMD_PRE, DPH_CMD_REF, DPH_CMD_MRS
  } dph_cmd_t;

  typedef enum logic [2:0] {
    DPH_INIT_IDLE, DPH_INIT_GAP, DPH_INIT_MRS, DPH_INIT_WLV, DPH_INIT_DONE
  } dph_init_st_t;

  typedef enum logic [1:0] {
    DPH_LNK_INIT, DPH_LNK_IDLE, DPH_LNK_WLAT, DPH_LNK_WDAT
  } dph_lnk_st_t;

  // Row, column and write strobe levels for a command
  function automatic logic [2:0] dph_cmd_pins(input dph_cmd_t cmd);
    case (cmd)
      DPH_CMD_ACT: dph_cmd_pins = 3'h3;
      DPH_CMD_RD: dph_cmd_pins = 3'h5;
      DPH_CMD_WR: dph_cmd_pins = 3'h4;
      DPH_CMD_PRE: dph_cmd_pins = 3'h2;
      DPH_CMD_REF: dph_cmd_pins = 3'h1;
      DPH_CMD_MRS: dph_cmd_pins = 3'h0;
      default: dph_cmd_pins = 3'h7;
    endcase
  endfunction : dph_cmd_pins

  // True when the strobes carry a read to a selected rank
  function automatic logic dph_is_read(input logic any_cs, input logic [2:0] pins);
    dph_is_read = any_cs && (pins == 3'h5);
  endfunction : dph_is_read
endpackage : dph_pkg

// file: hw/dph_dfi_if.sv
// DFI link between the memory controller end and the PHY end
`timescale 1ns/100ps
`default_nettype none
`include "dph_map.svh"
interface dph_dfi_if (
  input wire logic link_clk
);
  logic dfi_reset_n;
  logic [`DPH_AW-1:0] dfi_address;
  logic [`DPH_BW-1:0] dfi_bank;
  logic dfi_ras_n;
  logic dfi_cas_n;
  logic dfi_we_n;
  logic [`DPH_CSW-1:0] dfi_cs_n;
  logic [`DPH_CSW-1:0] dfi_odt;
  logic [`DPH_CKEW-1:0] dfi_cke;
  logic [`DPH_DW-1:0] dfi_wrdata;
  logic [`DPH_MW-1:0] dfi_wrdata_mask;
  logic dfi_wrdata_en;
  logic [`DPH_DW-1:0] dfi_rddata;
  logic dfi_rddata_valid;
  logic dfi_init_start;
  logic dfi_init_complete;

  modport phy (
    input link_clk, dfi_reset_n, dfi_address, dfi_bank, dfi_ras_n, dfi_cas_n,
    input dfi_we_n, dfi_cs_n, dfi_odt, dfi_cke, dfi_wrdata, dfi_wrdata_mask,
    input dfi_wrdata_en, dfi_init_start,
    output dfi_rddata, dfi_rddata_valid, dfi_init_complete
  );

  modport mc (
    input link_clk, dfi_rddata, dfi_rddata_valid, dfi_init_complete,
    output dfi_reset_n, dfi_address, dfi_bank, dfi_ras_n, dfi_cas_n,
    output dfi_we_n, dfi_cs_n, dfi_odt, dfi_cke, dfi_wrdata, dfi_wrdata_mask,
    output dfi_wrdata_en, dfi_init_start
  );
endinterface : dph_dfi_if
`default_nettype wire

// file: hw/dph_phy_end.sv
// DDR3 PHY end: DFI in, memory pins out, initialization handshake
`timescale 1ns/100ps
`default_nettype none
`include "dph_map.svh"
module dph_phy_end #(
  parameter int GAP_CYCLES = `DPH_GAP_CYC,
  parameter int MRS_CYCLES = `DPH_MRS_CYC,
  parameter int WLV_CYCLES = `DPH_WLV_CYC
) (
  // DFI link, clocked by the link clock
  dph_dfi_if.phy dfi,
  // Memory-only reset from the user
  input wire logic mem_rst_in_n,
  // Memory reset and clocks
  output logic mem_reset_out_n,
  output logic [`DPH_CLKOW-1:0] mem_clock_out,
  output logic [`DPH_CLKOW-1:0] mem_clock_comp_out,
  output logic [`DPH_CKEW-1:0] mem_clock_enable_out,
  // Memory command and address
  output logic [`DPH_AW-1:0] mem_address_out,
  output logic [`DPH_BW-1:0] mem_bank_out,
  output logic [`DPH_CSW-1:0] mem_chip_select_out_n,
  output logic mem_row_strobe_out_n,
  output logic mem_column_strobe_out_n,
  output logic mem_write_enable_out_n,
  output logic [`DPH_CSW-1:0] mem_termination_out,
  // Memory data pins
  input wire logic [`DPH_DW-1:0] mem_data_in,
  output logic [`DPH_DW-1:0] mem_data_out,
  output logic mem_data_oe,
  output logic [`DPH_MW-1:0] mem_write_mask_out,
  // Memory strobe pins, true and complement
  input wire logic [`DPH_DQSW-1:0] mem_strobe_in,
  input wire logic [`DPH_DQSW-1:0] mem_strobe_comp_in,
  output logic [`DPH_DQSW-1:0] mem_strobe_out,
  output logic [`DPH_DQSW-1:0] mem_strobe_comp_out,
  output logic mem_strobe_oe,
  // Progress status
  output logic phy_init_active,
  output logic wl_active
);
  localparam int RD_LAT = `DPH_RD_LAT;
  localparam int BURST = `DPH_BURST_WORDS;

  logic clk, rst_meta_n_reg, rst_n_reg, mrst_meta_n_reg, mrst_n_reg;
  dph_pkg::dph_init_st_t st_reg;
  logic [`DPH_CNT_W-1:0] cnt_reg;
  logic cke_ok_reg, done_reg, init_busy, rd_cmd, valid_reg, mck_reg, wr_en_reg, dqs_ph_reg;
  logic [2:0] cmd_pins;
  logic [RD_LAT-2:0] rd_pipe_reg;
  logic [1:0] burst_left_reg;
  logic [`DPH_DW-1:0] rdata_reg, din_meta_reg, din_sync_reg, wdata_reg;
  logic [`DPH_DQSW-1:0] dqs_meta_reg, dqs_sync_reg, dqsn_meta_reg, dqsn_sync_reg;
  logic [`DPH_MW-1:0] wmask_reg;

  assign clk = dfi.link_clk;

  // DFI reset, asserts at once, releases on the clock
  always_ff @(posedge clk or negedge dfi.dfi_reset_n) begin
    if (!dfi.dfi_reset_n) begin
      rst_meta_n_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_n_reg <= 1'b1;
      rst_n_reg <= rst_meta_n_reg;
    end
  end

  // memory-only reset, kept apart from device logic
  always_ff @(posedge clk or negedge mem_rst_in_n) begin
    if (!mem_rst_in_n) begin
      mrst_meta_n_reg <= 1'b0;
      mrst_n_reg <= 1'b0;
    end else begin
      mrst_meta_n_reg <= 1'b1;
      mrst_n_reg <= mrst_meta_n_reg;
    end
  end

  // memory reset low while either reset is active
  assign mem_reset_out_n = rst_n_reg & mrst_n_reg;

  // Initialization sequencer; restarts if the request stays high
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= dph_pkg::DPH_INIT_IDLE;
      cnt_reg <= '0;
      cke_ok_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (st_reg)
        dph_pkg::DPH_INIT_IDLE: begin
          if (dfi.dfi_init_start && !done_reg) begin // Old request still high at the pulse
            st_reg <= dph_pkg::DPH_INIT_GAP;
            cnt_reg <= '0;
            cke_ok_reg <= 1'b0;
          end
        end
        dph_pkg::DPH_INIT_GAP: begin
          // Gap counted only while memory reset is released
          if (!mem_reset_out_n) begin
            cnt_reg <= '0;
          end else if (cnt_reg == `DPH_CNT_W'(GAP_CYCLES - 1)) begin
            st_reg <= dph_pkg::DPH_INIT_MRS;
            cnt_reg <= '0;
            cke_ok_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + `DPH_CNT_W'(1);
          end
        end
        dph_pkg::DPH_INIT_MRS: begin
          if (cnt_reg == `DPH_CNT_W'(MRS_CYCLES - 1)) begin
            st_reg <= dph_pkg::DPH_INIT_WLV;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + `DPH_CNT_W'(1);
          end
        end
        dph_pkg::DPH_INIT_WLV: begin
          if (cnt_reg == `DPH_CNT_W'(WLV_CYCLES - 1)) begin
            st_reg <= dph_pkg::DPH_INIT_DONE;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + `DPH_CNT_W'(1);
          end
        end
        dph_pkg::DPH_INIT_DONE: begin
          done_reg <= 1'b1;
          st_reg <= dph_pkg::DPH_INIT_IDLE;
        end
        default: st_reg <= dph_pkg::DPH_INIT_IDLE;
      endcase
    end
  end

  assign init_busy = (st_reg != dph_pkg::DPH_INIT_IDLE);
  assign dfi.dfi_init_complete = done_reg;
  assign phy_init_active = init_busy && (st_reg != dph_pkg::DPH_INIT_WLV);
  assign wl_active = (st_reg == dph_pkg::DPH_INIT_WLV);

  // memory clock at half the link rate, with complement
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mck_reg <= 1'b0;
    end else begin
      mck_reg <= ~mck_reg;
    end
  end

  assign mem_clock_out = {`DPH_CLKOW{mck_reg}};
  assign mem_clock_comp_out = {`DPH_CLKOW{~mck_reg}};

  // one register stage for every control signal
  // Commands during initialization are masked to no-operation
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mem_address_out <= '0;
      mem_bank_out <= '0;
      mem_chip_select_out_n <= '1;
      mem_row_strobe_out_n <= 1'b1;
      mem_column_strobe_out_n <= 1'b1;
      mem_write_enable_out_n <= 1'b1;
      mem_termination_out <= '0;
      mem_clock_enable_out <= '0;
    end else begin
      // row and column share the address pins
      mem_address_out <= dfi.dfi_address;
      mem_bank_out <= dfi.dfi_bank;
      mem_chip_select_out_n <= init_busy ? '1 : dfi.dfi_cs_n;
      mem_row_strobe_out_n <= dfi.dfi_ras_n;
      mem_column_strobe_out_n <= dfi.dfi_cas_n;
      mem_write_enable_out_n <= dfi.dfi_we_n;
      mem_termination_out <= init_busy ? '0 : dfi.dfi_odt;
      mem_clock_enable_out <= cke_ok_reg ? dfi.dfi_cke : '0;
    end
  end

  // data and mask taken together under the enable
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wr_en_reg <= 1'b0;
      wdata_reg <= '0;
      wmask_reg <= '0;
    end else begin
      wr_en_reg <= dfi.dfi_wrdata_en;
      if (dfi.dfi_wrdata_en) begin
        wdata_reg <= dfi.dfi_wrdata;
        wmask_reg <= dfi.dfi_wrdata_mask;
      end
    end
  end

  assign mem_data_out = wdata_reg;
  assign mem_data_oe = wr_en_reg;
  // one mask pin per byte, masked only while writing
  assign mem_write_mask_out = wr_en_reg ? wmask_reg : '0;

  // strobe phase toggles each write beat
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dqs_ph_reg <= 1'b0;
    end else begin
      dqs_ph_reg <= dfi.dfi_wrdata_en ? ~dqs_ph_reg : 1'b0;
    end
  end

  // per-lane strobe drivers, released during reads
  genvar g;
  generate
    for (g = 0; g < `DPH_DQSW; g++) begin : g_lane
      assign mem_strobe_out[g] = dqs_ph_reg;
      assign mem_strobe_comp_out[g] = ~dqs_ph_reg;
    end
  endgenerate
  assign mem_strobe_oe = wr_en_reg;

  // Pins from memory pass two flops before use
  always_ff @(posedge clk) begin
    din_meta_reg <= mem_data_in;
    din_sync_reg <= din_meta_reg;
    dqs_meta_reg <= mem_strobe_in;
    dqs_sync_reg <= dqs_meta_reg;
    dqsn_meta_reg <= mem_strobe_comp_in;
    dqsn_sync_reg <= dqsn_meta_reg;
  end

  // Read seen on the link; ignored during initialization
  assign cmd_pins = {dfi.dfi_ras_n, dfi.dfi_cas_n, dfi.dfi_we_n};
  assign rd_cmd = !init_busy && dph_pkg::dph_is_read(~&dfi.dfi_cs_n, cmd_pins);

  // Fixed read latency; a shift register keeps back-to-back reads apart
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_pipe_reg <= '0;
    end else begin
      rd_pipe_reg <= {rd_pipe_reg[RD_LAT-3:0], rd_cmd};
    end
  end

  // valid high only on returned words
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      valid_reg <= 1'b0;
      burst_left_reg <= '0;
      rdata_reg <= '0;
    end else begin
      valid_reg <= rd_pipe_reg[RD_LAT-2] || (burst_left_reg != 2'h0);
      if (rd_pipe_reg[RD_LAT-2]) begin
        burst_left_reg <= 2'(BURST - 1);
      end else if (burst_left_reg != 2'h0) begin
        burst_left_reg <= burst_left_reg - 2'h1;
      end
      if (rd_pipe_reg[RD_LAT-2] || (burst_left_reg != 2'h0)) begin
        rdata_reg <= din_sync_reg;
      end
    end
  end

  assign dfi.dfi_rddata = rdata_reg;
  assign dfi.dfi_rddata_valid = valid_reg;
endmodule : dph_phy_end
`default_nettype wire

// file: hw/dph_mc_end.sv
// DFI controller end: user requests on core clock, DFI on link clock
`timescale 1ns/100ps
`default_nettype none
`include "dph_map.svh"
module dph_mc_end (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire dph_pkg::dph_cmd_t req_cmd,
  input wire logic [`DPH_BW-1:0] req_bank,
  input wire logic [`DPH_AW-1:0] req_addr,
  input wire logic [`DPH_DW-1:0] req_wdata,
  input wire logic [`DPH_MW-1:0] req_mask,
  // User response and status
  output logic rsp_valid,
  output logic [`DPH_DW-1:0] rsp_data,
  output logic init_done,
  // DFI link
  dph_dfi_if.mc dfi
);
  logic lclk;
  logic req_tgl_reg;
  dph_pkg::dph_cmd_t h_cmd_reg;
  logic [`DPH_BW-1:0] h_bank_reg;
  logic [`DPH_AW-1:0] h_addr_reg;
  logic [`DPH_DW-1:0] h_wdata_reg;
  logic [`DPH_MW-1:0] h_mask_reg;
  logic [1:0] ack_s_reg;
  logic [2:0] rsp_s_reg;
  logic [1:0] ini_s_reg;
  logic [1:0] lrst_s_reg;
  logic [2:0] rq_s_reg;
  logic ack_tgl_reg;
  logic lrsp_tgl_reg;
  logic [`DPH_DW-1:0] lrsp_data_reg;
  logic linit_done_reg;
  dph_pkg::dph_lnk_st_t lst_reg;
  logic [1:0] wl_cnt_reg;

  assign lclk = dfi.link_clk;

  // Core side: one request in flight, stable until acknowledged
  // no command accepted before initialization ends
  assign req_ready = ini_s_reg[1] && (ack_s_reg[1] == req_tgl_reg) && !sys_rst;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_tgl_reg <= 1'b0;
      h_cmd_reg <= dph_pkg::DPH_CMD_NOP;
      h_bank_reg <= '0;
      h_addr_reg <= '0;
      h_wdata_reg <= '0;
      h_mask_reg <= '0;
    end else if (req_valid && req_ready) begin
      req_tgl_reg <= ~req_tgl_reg;
      h_cmd_reg <= req_cmd;
      h_bank_reg <= req_bank;
      h_addr_reg <= req_addr;
      h_wdata_reg <= req_wdata;
      h_mask_reg <= req_mask;
    end
  end

  // Core side synchronisers and response pulse
  always_ff @(posedge core_clk) begin
    ack_s_reg <= {ack_s_reg[0], ack_tgl_reg};
    ini_s_reg <= {ini_s_reg[0], linit_done_reg};
    rsp_s_reg <= {rsp_s_reg[1:0], lrsp_tgl_reg};
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= rsp_s_reg[2] ^ rsp_s_reg[1];
      if (rsp_s_reg[2] ^ rsp_s_reg[1]) begin
        rsp_data <= lrsp_data_reg;
      end
    end
  end

  assign init_done = ini_s_reg[1];

  // Link side: reset and request toggle brought across
  always_ff @(posedge lclk) begin
    lrst_s_reg <= {lrst_s_reg[0], sys_rst};
    rq_s_reg <= {rq_s_reg[1:0], req_tgl_reg};
  end

  // Link side sequencer and DFI drivers
  always_ff @(posedge lclk) begin
    if (lrst_s_reg[1]) begin
      lst_reg <= dph_pkg::DPH_LNK_INIT;
      dfi.dfi_reset_n <= 1'b0;
      dfi.dfi_init_start <= 1'b0;
      dfi.dfi_cs_n <= '1;
      {dfi.dfi_ras_n, dfi.dfi_cas_n, dfi.dfi_we_n} <= 3'h7;
      dfi.dfi_address <= '0;
      dfi.dfi_bank <= '0;
      dfi.dfi_odt <= '0;
      dfi.dfi_cke <= '0;
      dfi.dfi_wrdata <= '0;
      dfi.dfi_wrdata_mask <= '0;
      dfi.dfi_wrdata_en <= 1'b0;
      ack_tgl_reg <= rq_s_reg[2];
      linit_done_reg <= 1'b0;
      wl_cnt_reg <= '0;
    end else begin
      dfi.dfi_reset_n <= 1'b1;
      dfi.dfi_cke <= '1;
      dfi.dfi_cs_n <= '1;
      {dfi.dfi_ras_n, dfi.dfi_cas_n, dfi.dfi_we_n} <= 3'h7;
      dfi.dfi_odt <= '0;
      dfi.dfi_wrdata_en <= 1'b0;
      case (lst_reg)
        dph_pkg::DPH_LNK_INIT: begin
          // request initialization once out of reset
          dfi.dfi_init_start <= 1'b1;
          // drop the request at the completion edge
          if (dfi.dfi_init_complete) begin
            dfi.dfi_init_start <= 1'b0;
            linit_done_reg <= 1'b1;
            lst_reg <= dph_pkg::DPH_LNK_IDLE;
          end
        end
        dph_pkg::DPH_LNK_IDLE: begin
          if (rq_s_reg[2] != rq_s_reg[1]) begin
            dfi.dfi_cs_n <= '0;
            {dfi.dfi_ras_n, dfi.dfi_cas_n, dfi.dfi_we_n} <= dph_pkg::dph_cmd_pins(h_cmd_reg);
            dfi.dfi_address <= h_addr_reg;
            dfi.dfi_bank <= h_bank_reg;
            if (h_cmd_reg == dph_pkg::DPH_CMD_WR) begin
              dfi.dfi_odt <= '1;
              wl_cnt_reg <= 2'(`DPH_WR_LAT - 2); // Command and data states count too
              lst_reg <= dph_pkg::DPH_LNK_WLAT;
            end else begin
              ack_tgl_reg <= rq_s_reg[1];
            end
          end
        end
        dph_pkg::DPH_LNK_WLAT: begin
          if (wl_cnt_reg == 2'h0) begin
            lst_reg <= dph_pkg::DPH_LNK_WDAT;
          end else begin
            wl_cnt_reg <= wl_cnt_reg - 2'h1;
          end
        end
        dph_pkg::DPH_LNK_WDAT: begin
          // mask per byte, with data, under one enable
          dfi.dfi_wrdata_en <= 1'b1;
          dfi.dfi_wrdata <= h_wdata_reg;
          dfi.dfi_wrdata_mask <= h_mask_reg;
          ack_tgl_reg <= rq_s_reg[2];
          lst_reg <= dph_pkg::DPH_LNK_IDLE;
        end
        default: lst_reg <= dph_pkg::DPH_LNK_INIT;
      endcase
    end
  end

  // Read words held for the core side, one toggle per word
  always_ff @(posedge lclk) begin
    if (lrst_s_reg[1]) begin
      lrsp_tgl_reg <= 1'b0;
      lrsp_data_reg <= '0;
    end else if (dfi.dfi_rddata_valid) begin
      lrsp_tgl_reg <= ~lrsp_tgl_reg;
      lrsp_data_reg <= dfi.dfi_rddata;
    end
  end
endmodule : dph_mc_end
`default_nettype wire

// file: tb/dph_dfi_sva.sv
// Assertions on the DFI link between the controller end and the PHY end
`timescale 1ns/100ps
`default_nettype none
`include "dph_map.svh"
module dph_dfi_sva (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic dfi_reset_n,
  // Command strobes
  input wire logic [`DPH_CSW-1:0] dfi_cs_n,
  input wire logic dfi_ras_n,
  input wire logic dfi_cas_n,
  input wire logic dfi_we_n,
  input wire logic [`DPH_CSW-1:0] dfi_odt,
  // Data and initialization handshake
  input wire logic dfi_wrdata_en,
  input wire logic dfi_rddata_valid,
  input wire logic dfi_init_start,
  input wire logic dfi_init_complete
);
  logic rd_cmd;
  logic wr_cmd;
  // Decoded commands to a selected rank
  assign rd_cmd = !dfi_cs_n[0] && dfi_ras_n && !dfi_cas_n && dfi_we_n;
  assign wr_cmd = !dfi_cs_n[0] && dfi_ras_n && !dfi_cas_n && !dfi_we_n;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!dfi_reset_n);
  AST_INIT_ONE_CYCLE: assert property (dfi_init_complete |=> !dfi_init_complete)
    else $error("init complete longer than one cycle");
  AST_INIT_WITH_REQ: assert property (dfi_init_complete |-> dfi_init_start)
    else $error("init complete without a request");
  AST_INIT_DROP: assert property (dfi_init_complete |=> !dfi_init_start)
    else $error("init request not dropped after complete");
  AST_INIT_HOLD: assert property (dfi_init_start && !dfi_init_complete |=> dfi_init_start)
    else $error("init request dropped early");
  AST_RD_RETURN: assert property (rd_cmd |-> ##12 dfi_rddata_valid [*2] ##1 !dfi_rddata_valid)
    else $error("read words not valid at latency 12 for two cycles");
  AST_RD_CAUSE: assert property ($rose(dfi_rddata_valid) |-> $past(rd_cmd, 12))
    else $error("read valid without a read command");
  AST_WR_DATA: assert property (wr_cmd |-> ##3 dfi_wrdata_en ##1 !dfi_wrdata_en)
    else $error("write enable not three cycles after write");
  AST_WR_CAUSE: assert property (dfi_wrdata_en |-> $past(wr_cmd, 3))
    else $error("write enable without a write command");
  AST_ODT_WR: assert property (wr_cmd |-> dfi_odt[0])
    else $error("termination missing on write command");
  AST_ODT_ONLY_WR: assert property (dfi_odt[0] |-> wr_cmd)
    else $error("termination without a write command");
endmodule : dph_dfi_sva
`default_nettype wire

// file: tb/dfi_ddr3_phy_port_tb.sv
// Bench joining the controller end and the PHY end over the DFI link
`timescale 1ns/100ps
`default_nettype none
`include "dph_map.svh"
module dfi_ddr3_phy_port_tb;
  logic core_clk, link_clk, sys_rst, req_valid, req_ready, rsp_valid, init_done;
  logic mem_rst_in_n, mem_reset_out_n, mem_data_oe, mem_strobe_oe, p_init, p_wl;
  logic row_n, col_n, we_n, oe_prev, clk_prev;
  logic [0:0] mck, mck_n, cke, cs_n, odt;
  logic [2:0] bank, req_bank;
  logic [13:0] addr, req_addr;
  logic [31:0] rsp_data, req_wdata, d_out, d_in, rd_word, seed;
  logic [3:0] req_mask, dm;
  logic [1:0] s_out, s_comp, s_in, s_comp_in;
  logic [35:0] pin_q[$], wq[$], rsp_q[$], e;
  dph_pkg::dph_cmd_t req_cmd;
  int bad_count, num_checks, pend;
  // Released pins show the last read word while a read is pending, its inverse otherwise
  assign d_in = mem_data_oe ? d_out : (pend != 0 ? rd_word : ~rd_word);
  assign s_in = mem_strobe_oe ? s_out : {2{link_clk}};
  assign s_comp_in = mem_strobe_oe ? s_comp : {2{~link_clk}};
  dph_dfi_if i_dph_dfi_if (.link_clk(link_clk));
  dph_mc_end i_dph_mc_end (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_mask(req_mask), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_done(init_done), .dfi(i_dph_dfi_if));
  dph_phy_end #(.GAP_CYCLES(20), .MRS_CYCLES(4), .WLV_CYCLES(4)) i_dph_phy_end (
    .dfi(i_dph_dfi_if), .mem_rst_in_n(mem_rst_in_n), .mem_reset_out_n(mem_reset_out_n),
    .mem_clock_out(mck), .mem_clock_comp_out(mck_n), .mem_clock_enable_out(cke),
    .mem_address_out(addr), .mem_bank_out(bank), .mem_chip_select_out_n(cs_n),
    .mem_row_strobe_out_n(row_n), .mem_column_strobe_out_n(col_n),
    .mem_write_enable_out_n(we_n), .mem_termination_out(odt), .mem_data_in(d_in),
    .mem_data_out(d_out), .mem_data_oe(mem_data_oe), .mem_write_mask_out(dm),
    .mem_strobe_in(s_in), .mem_strobe_comp_in(s_comp_in), .mem_strobe_out(s_out),
    .mem_strobe_comp_out(s_comp), .mem_strobe_oe(mem_strobe_oe), .phy_init_active(p_init),
    .wl_active(p_wl));
  dph_dfi_sva i_dph_dfi_sva (.link_clk(link_clk), .dfi_reset_n(i_dph_dfi_if.dfi_reset_n),
    .dfi_cs_n(i_dph_dfi_if.dfi_cs_n), .dfi_ras_n(i_dph_dfi_if.dfi_ras_n),
    .dfi_cas_n(i_dph_dfi_if.dfi_cas_n), .dfi_we_n(i_dph_dfi_if.dfi_we_n),
    .dfi_odt(i_dph_dfi_if.dfi_odt), .dfi_wrdata_en(i_dph_dfi_if.dfi_wrdata_en),
    .dfi_rddata_valid(i_dph_dfi_if.dfi_rddata_valid),
    .dfi_init_start(i_dph_dfi_if.dfi_init_start),
    .dfi_init_complete(i_dph_dfi_if.dfi_init_complete));
  // Core clock, and a link clock with an unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Row, column and write strobe levels expected per command
  function automatic logic [2:0] pins_of(input dph_pkg::dph_cmd_t c);
    case (c)
      dph_pkg::DPH_CMD_ACT: return 3'h3;
      dph_pkg::DPH_CMD_RD: return 3'h5;
      dph_pkg::DPH_CMD_WR: return 3'h4;
      dph_pkg::DPH_CMD_PRE: return 3'h2;
      dph_pkg::DPH_CMD_REF: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : pins_of
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One request; waits until the previous one and its read words are through
  task automatic send(input dph_pkg::dph_cmd_t c);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while ((req_ready !== 1'b1 || pend != 0) && n < 3000);
    chk("ready wait", 36'h0, 36'(n >= 3000));
    r = rnd();
    req_cmd = c;
    req_bank = r[16:14];
    req_addr = r[13:0];
    req_mask = r[20:17];
    req_wdata = rnd();
    req_valid = 1'b1;
    pin_q.push_back({15'h0, c == dph_pkg::DPH_CMD_WR, pins_of(c), r[16:0]});
    if (c == dph_pkg::DPH_CMD_WR) begin
      wq.push_back({r[20:17], req_wdata});
    end
    if (c == dph_pkg::DPH_CMD_RD) begin
      rd_word = rnd();
      pend = 2;
      rsp_q.push_back({4'h0, rd_word});
      rsp_q.push_back({4'h0, rd_word});
    end
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask : send
  task automatic wait_init();
    int n;
    logic [1:0] seen;
    n = 0;
    seen = 2'h0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      seen = seen | {p_init, p_wl};
      n++;
    end
    chk("init wait", 36'h0, 36'(n >= 3000));
    chk("init phases seen", 36'h3, {34'h0, seen});
  endtask : wait_init
  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Memory pin watcher, sampled where the link flops have settled
  always @(negedge link_clk) begin
    if (sys_rst === 1'b0 && cs_n === 1'b0) begin
      e = (pin_q.size() != 0) ? pin_q.pop_front() : 36'hF00000000;
      chk("pins", e, {odt, row_n, col_n, we_n, bank, addr});
    end
    if (mem_data_oe === 1'b1 && oe_prev !== 1'b1) begin
      e = (wq.size() != 0) ? wq.pop_front() : 36'hF00000000;
      chk("write word", e, {dm, d_out});
      chk("strobe pair", {34'h0, ~s_out}, {34'h0, s_comp});
      chk("strobe oe", 36'h1, {35'h0, mem_strobe_oe});
    end
    if (init_done === 1'b1) begin
      chk("clock pair", {35'h0, ~mck}, {35'h0, mck_n});
      chk("clock toggle", {35'h0, ~clk_prev}, {35'h0, mck});
    end
    oe_prev = mem_data_oe;
    clk_prev = mck[0];
  end
  // Response watcher against the oldest noted read word
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      e = (rsp_q.size() != 0) ? rsp_q.pop_front() : 36'hF00000000;
      chk("read word", e, {4'h0, rsp_data});
      pend = (pend > 0) ? pend - 1 : 0;
    end
  end
  initial begin
    #400000;
    chk("watchdog", 36'h0, 36'h1);
    final_report();
  end
  initial begin
    seed = 32'h643C14E9;
    {sys_rst, req_valid, mem_rst_in_n, pend, bad_count, num_checks} = {3'b101, 96'h0};
    {req_bank, req_addr, req_wdata, req_mask, rd_word} = '0;
    req_cmd = dph_pkg::DPH_CMD_NOP;
    repeat (6) @(posedge link_clk);
    @(negedge core_clk);
    chk("reset pin in reset", 36'h0, {35'h0, mem_reset_out_n});
    sys_rst = 1'b0;
    wait_init();
    chk("reset pin after init", 36'h1, {35'h0, mem_reset_out_n});
    chk("cke and status", 36'h4, {33'h0, cke, p_init, p_wl});
    for (int i = 1; i < 7; i++) begin
      send(dph_pkg::dph_cmd_t'(i));
    end
    repeat (24) send(rnd() % 2 ? dph_pkg::DPH_CMD_RD : dph_pkg::DPH_CMD_WR);
    repeat (30) @(posedge link_clk);
    @(negedge core_clk);
    // Memory-only reset leaves the PHY initialized
    mem_rst_in_n = 1'b0;
    #1;
    chk("memory-only reset", 36'h0, {35'h0, mem_reset_out_n});
    repeat (4) @(posedge link_clk);
    @(negedge core_clk);
    mem_rst_in_n = 1'b1;
    repeat (4) @(posedge link_clk);
    @(negedge core_clk);
    chk("after memory reset", 36'h3, {34'h0, mem_reset_out_n, init_done});
    send(dph_pkg::DPH_CMD_RD);
    send(dph_pkg::DPH_CMD_WR);
    repeat (30) @(posedge link_clk);
    @(negedge core_clk);
    // Second core reset in mid-run resets memory and needs a new init
    sys_rst = 1'b1;
    repeat (6) @(posedge link_clk);
    @(negedge core_clk);
    chk("mid-run reset", 36'h0, {34'h0, mem_reset_out_n, init_done});
    sys_rst = 1'b0;
    wait_init();
    send(dph_pkg::DPH_CMD_RD);
    send(dph_pkg::DPH_CMD_WR);
    repeat (40) @(posedge link_clk);
    @(negedge core_clk);
    chk("left over", 36'h0, 36'(pin_q.size() + wq.size() + rsp_q.size()));
    final_report();
  end
endmodule : dfi_ddr3_phy_port_tb
`default_nettype wire
